/* logic/port8_io.sv */
// port 8 general-purpose I/O with output style registers for ports 1, 7 and 8
`timescale 1ns/1ns
`default_nettype none
`include "port8_map.svh"
module port8_io (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // memory access port
    input wire logic [19:0] addr,
    input wire logic byte_wr,
    input wire logic [7:0] wr_data,
    input wire logic bit_wr,
    input wire logic [2:0] bit_pos,
    input wire logic bit_val,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_en,
    // alternate functions driving the pins
    input wire logic [7:0] alt_out_sel,
    input wire logic [7:0] alt_out_val,
    // alternate function inputs
    output logic serial_ch0_clock_pin,
    output logic serial_ch0_data_in,
    output logic ext_interrupt_11,
    output logic ext_interrupt_9,
    output logic timer_ch10_input,
    // output style of other ports' pads
    output logic [7:0] port1_output_style_reg,
    output logic [7:0] port7_output_style_reg
);
    port8_pkg::byte_t port8_latch;
    port8_pkg::byte_t port8_direction_reg;
    port8_pkg::byte_t port8_pullup_option_reg;
    port8_pkg::byte_t port8_output_style_reg;
    port8_pkg::byte_t pin_level;
    port8_pkg::byte_t wr_value;
    port8_pkg::byte_t cur_value;
    port8_pkg::byte_t next_pin_out;
    port8_pkg::byte_t next_pin_oe;
    port8_pkg::reg_sel_t sel;
    logic any_wr;

    pin_sync #(.WIDTH(8)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    always_comb begin
        case (addr)
            `ADDR_PORT8_DATA: sel = port8_pkg::sel_data;
            `ADDR_PORT8_DIR: sel = port8_pkg::sel_dir;
            `ADDR_PORT8_PULLUP: sel = port8_pkg::sel_pullup;
            `ADDR_PORT1_STYLE: sel = port8_pkg::sel_style1;
            `ADDR_PORT7_STYLE: sel = port8_pkg::sel_style7;
            `ADDR_PORT8_STYLE: sel = port8_pkg::sel_style8;
            default: sel = port8_pkg::sel_none;
        endcase
    end

    // current register contents, used for reads and for bit writes to every register but the data latch
    always_comb begin
        case (sel)
            port8_pkg::sel_data: cur_value = (pin_level & port8_direction_reg)
                | (port8_latch & ~port8_direction_reg);
            port8_pkg::sel_dir: cur_value = port8_direction_reg;
            port8_pkg::sel_pullup: cur_value = port8_pullup_option_reg;
            port8_pkg::sel_style1: cur_value = port1_output_style_reg;
            port8_pkg::sel_style7: cur_value = port7_output_style_reg;
            port8_pkg::sel_style8: cur_value = port8_output_style_reg;
            default: cur_value = 8'h00;
        endcase
    end

    // a bit write is a read-modify-write of the byte; for the data register
    // the base is the latch so input bits do not pick up the pin level
    always_comb begin
        wr_value = (sel == port8_pkg::sel_data) ? port8_latch : cur_value;
        if (bit_wr) begin
            wr_value[bit_pos] = bit_val;
        end else begin
            wr_value = wr_data;
        end
    end

    assign any_wr = byte_wr | bit_wr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port8_latch <= `RESET_PORT8_DATA;
        end else if (any_wr && sel == port8_pkg::sel_data) begin
            port8_latch <= wr_value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port8_direction_reg <= `RESET_PORT8_DIR;
        end else if (any_wr && sel == port8_pkg::sel_dir) begin
            port8_direction_reg <= wr_value;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port8_pullup_option_reg <= `RESET_PORT8_PULLUP;
        end else if (any_wr && sel == port8_pkg::sel_pullup) begin
            port8_pullup_option_reg <= wr_value;
        end
    end

    // unimplemented style bits are held at zero and read back as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port1_output_style_reg <= `RESET_STYLE;
            port7_output_style_reg <= `RESET_STYLE;
            port8_output_style_reg <= `RESET_STYLE;
        end else if (any_wr) begin
            if (sel == port8_pkg::sel_style1) begin
                port1_output_style_reg <= wr_value & `MASK_PORT1_STYLE;
            end
            if (sel == port8_pkg::sel_style7) begin
                port7_output_style_reg <= wr_value & `MASK_PORT7_STYLE;
            end
            if (sel == port8_pkg::sel_style8) begin
                port8_output_style_reg <= wr_value & `MASK_PORT8_STYLE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            rd_data <= cur_value;
        end
    end

    // pad drive; alternate function supplies the value of a pin it claims, the direction bit still sets the enable
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            logic drive_val;
            drive_val = 1'b0;
            drive_val = alt_out_sel[i] ? alt_out_val[i] : port8_latch[i];
            if (port8_output_style_reg[i]) begin
                next_pin_out[i] = 1'b0;
                next_pin_oe[i] = ~port8_direction_reg[i] & ~drive_val;
            end else begin
                next_pin_out[i] = drive_val;
                next_pin_oe[i] = ~port8_direction_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 8'h00;
            pin_oe <= 8'h00;
            pullup_en <= 8'h00;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pullup_en <= port8_pullup_option_reg & port8_direction_reg;
        end
    end

    // alternate inputs see the synchronised pin level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_ch0_clock_pin <= 1'b0;
            serial_ch0_data_in <= 1'b0;
            ext_interrupt_11 <= 1'b0;
            ext_interrupt_9 <= 1'b0;
            timer_ch10_input <= 1'b0;
        end else begin
            serial_ch0_clock_pin <= pin_level[0];
            serial_ch0_data_in <= pin_level[1];
            ext_interrupt_11 <= pin_level[0];
            ext_interrupt_9 <= pin_level[1];
            timer_ch10_input <= pin_level[4];
        end
    end
endmodule
`default_nettype wire

/* pkg/port8_map.svh */
// register offsets, write masks and reset values of the port 8 block
// How it works
// - each port 8 pin has its own direction bit, input or output
// - an output latch holds the value driven on every output pin not claimed by an alternate function
// - input pins get a pull-up per bit from the pull-up option register
// - only port 8 bits 0 and 2 may select open-drain output
// - reset puts every port 8 pin into input mode
// - pins are shared with serial, timer and external interrupt functions
// - output style registers cover port 1 bits 0-5, port 7 bits 5,7, port 8 bits 0,2
// - output style registers take single-bit and whole-byte writes
// - reset clears all output style registers, giving push-pull everywhere
`ifndef PORT8_MAP_SVH
`define PORT8_MAP_SVH

`define ADDR_PORT8_DATA 20'hFFF08
`define ADDR_PORT8_DIR 20'hFFF28
`define ADDR_PORT8_PULLUP 20'hF0038
`define ADDR_PORT1_STYLE 20'hF0051
`define ADDR_PORT7_STYLE 20'hF0057
`define ADDR_PORT8_STYLE 20'hF0058

`define MASK_PORT1_STYLE 8'h3F
`define MASK_PORT7_STYLE 8'hA0
`define MASK_PORT8_STYLE 8'h05

`define RESET_PORT8_DATA 8'h00
`define RESET_PORT8_DIR 8'hFF
`define RESET_PORT8_PULLUP 8'h00
`define RESET_STYLE 8'h00

`endif

/* pkg/port8_pkg.sv */
// types shared by the port 8 block
package port8_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [2:0] {
        sel_none,
        sel_data,
        sel_dir,
        sel_pullup,
        sel_style1,
        sel_style7,
        sel_style8
    } reg_sel_t;
endpackage

/* logic/pin_sync.sv */
// two-flop synchroniser, one per pin bit
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // refuse a width the loop cannot build
    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("pin_sync: WIDTH must be at least 1");
        end
    endgenerate

    // each bit owns its flops, so no two processes write one vector
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            logic settled;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= 1'b0;
                    settled <= 1'b0;
                end else begin
                    meta <= async_in[i];
                    settled <= meta;
                end
            end
            assign sync_out[i] = settled;
        end
    endgenerate
endmodule
`default_nettype wire

/* test/pad_model.sv */
// far-side pad model for the port 8 pins
`timescale 1ns/1ns
`default_nettype none
module pad_model (
    // port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    // far side
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_in
);
    // released pad shows the far side
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

/* test/port8_io_chk.sv */
// assertions on the port 8 block ports
`timescale 1ns/1ns
`default_nettype none
`include "port8_map.svh"
module port8_io_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // access
    input wire logic [19:0] addr,
    input wire logic byte_wr,
    input wire logic [7:0] wr_data,
    input wire logic bit_wr,
    input wire logic [2:0] bit_pos,
    input wire logic bit_val,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    // taps and styles
    input wire logic serial_ch0_clock_pin,
    input wire logic serial_ch0_data_in,
    input wire logic ext_interrupt_11,
    input wire logic ext_interrupt_9,
    input wire logic timer_ch10_input,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] port1_output_style_reg,
    input wire logic [7:0] port7_output_style_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_p1_byte;
        byte_wr && !bit_wr && addr == `ADDR_PORT1_STYLE;
    endsequence
    a_p1_byte_wr: assert property (s_p1_byte |=> port1_output_style_reg == ($past(wr_data) & 8'h3F))
        else $error("p1 byte write");
    a_p7_bit_wr: assert property (bit_wr && addr == `ADDR_PORT7_STYLE && bit_pos == 3'h7 |=> port7_output_style_reg[7] == $past(bit_val))
        else $error("p7 bit write");
    a_p1_mask: assert property ((port1_output_style_reg & 8'hC0) == 8'h00)
        else $error("p1 mask");
    a_p7_mask: assert property ((port7_output_style_reg & 8'h5F) == 8'h00)
        else $error("p7 mask");
    a_p7_hold: assert property (!((byte_wr || bit_wr) && addr == `ADDR_PORT7_STYLE) |=> $stable(port7_output_style_reg))
        else $error("p7 changed");
    a_rd_style: assert property (rd_en && addr == `ADDR_PORT1_STYLE |=> rd_data == $past(port1_output_style_reg))
        else $error("p1 read");
    a_rd_unmapped: assert property (rd_en && addr == 20'h00000 |=> rd_data == 8'h00)
        else $error("unmapped read");
    a_alt_taps: assert property ($past(rst_n, 1) && $past(rst_n, 2) && $past(rst_n, 3) |->
        serial_ch0_clock_pin == $past(pin_in[0], 3) && ext_interrupt_11 == $past(pin_in[0], 3)
        && serial_ch0_data_in == $past(pin_in[1], 3) && ext_interrupt_9 == $past(pin_in[1], 3)
        && timer_ch10_input == $past(pin_in[4], 3))
        else $error("taps differ");
endmodule
bind port8_io port8_io_chk u_chk (.*);
`default_nettype wire

/* test/port8_io_tb.sv */
// randomised bench for the port 8 block
`timescale 1ns/1ns
`default_nettype none
`include "port8_map.svh"
module port8_io_tb;
    logic clk = 1'b0, rst_n = 1'b0, byte_wr = 1'b0, bit_wr = 1'b0, bit_val = 1'b0, rd_en = 1'b0;
    logic [19:0] addr = 20'h00000;
    logic [2:0] bit_pos = 3'h0;
    logic [7:0] wr_data = 8'h00, asel = 8'h00, aval = 8'h00, ext = 8'h00, pin_in, pin_out, pin_oe, pu_en, rd_data;
    logic [7:0] dir = 8'hFF, lat = 8'h00, pu = 8'h00, s8 = 8'h00, v;
    logic [31:0] lfsr = 32'hDA4A;
    int err_total = 0;
    int n_checks = 0;
    always #4 clk = ~clk;
    port8_io u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .byte_wr(byte_wr), .wr_data(wr_data), .bit_wr(bit_wr),
        .bit_pos(bit_pos), .bit_val(bit_val), .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pu_en), .alt_out_sel(asel), .alt_out_val(aval), .serial_ch0_clock_pin(),
        .serial_ch0_data_in(), .ext_interrupt_11(), .ext_interrupt_9(), .timer_ch10_input(),
        .port1_output_style_reg(), .port7_output_style_reg());
    pad_model u_pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic bw);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        bit_pos <= d[2:0];
        bit_val <= d[7];
        byte_wr <= !bw;
        bit_wr <= bw;
        @(posedge clk);
        byte_wr <= 1'b0;
        bit_wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        chk(rd_data, e);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(pin_oe, 8'h00);
        rd(`ADDR_PORT8_DIR, 8'hFF);
        rd(`ADDR_PORT8_STYLE, 8'h00);
        wr(`ADDR_PORT1_STYLE, 8'hFF, 1'b0);
        wr(`ADDR_PORT7_STYLE, 8'hFF, 1'b0);
        rd(`ADDR_PORT1_STYLE, 8'h3F);
        wr(`ADDR_PORT7_STYLE, 8'h05, 1'b1);
        rd(`ADDR_PORT7_STYLE, 8'h80);
        wr(`ADDR_PORT7_STYLE, 8'h87, 1'b1);
        rd(`ADDR_PORT7_STYLE, 8'h80);
        rd(20'h00000, 8'h00);
        for (int i = 0; i < 60; i++) begin
            lfsr = next_rand(lfsr);
            dir = lfsr[7:0];
            lat = lfsr[15:8];
            pu = lfsr[23:16];
            @(posedge clk);
            ext <= lfsr[31:24];
            asel <= (i > 40) ? lfsr[19:12] : 8'h00;
            aval <= lfsr[27:20];
            wr(`ADDR_PORT8_DIR, dir, 1'b0);
            wr(`ADDR_PORT8_DATA, lat, 1'b0);
            // single-bit write to one latch bit
            wr(`ADDR_PORT8_DATA, {lfsr[3], 4'h0, lfsr[2:0]}, 1'b1);
            lat[lfsr[2:0]] = lfsr[3];
            wr(`ADDR_PORT8_PULLUP, pu, 1'b0);
            wr(`ADDR_PORT8_STYLE, lfsr[29:22], 1'b0);
            s8 = lfsr[29:22] & 8'h05;
            repeat (3) @(posedge clk);
            @(negedge clk);
            v = (asel & aval) | (~asel & lat);
            chk(pin_oe, ~dir & ~(s8 & v));
            chk(pin_out, v & ~s8);
            chk(pu_en, pu & dir);
            rd(`ADDR_PORT8_STYLE, s8);
            rd(`ADDR_PORT8_DATA, (dir & ext) | (~dir & lat));
        end
        // reset again after the random loop, ports must fall back
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(pin_oe, 8'h00);
        chk(pin_out, 8'h00);
        chk(pu_en, 8'h00);
        rd(`ADDR_PORT8_DIR, 8'hFF);
        rd(`ADDR_PORT8_STYLE, 8'h00);
        rd(`ADDR_PORT1_STYLE, 8'h00);
        end_sim;
    end
    initial begin
        #80000;
        err_total++;
        end_sim;
    end
endmodule
`default_nettype wire
